// file: pkg/irq_vector_pkg.sv
// Constants, field layouts and carrier types for the interrupt vector and mask unit.
//
// Notes on behaviour
// - 32 slots, each at eight times slot bytes.
// - Fixed priority per slot, lower value wins.
// - Two 16-bit enable registers mask maskable sources.
// - Two 16-bit flag registers hold pending requests.
// - Halted-enable registers apply only while core halted.
// - Halted: service needs both halted and normal enable.
// - Software sets or clears halted-enable bits directly.
// - Hardware reset zeroes flags, enables, halted enables.
// - Software reset zeroes flags, keeps all enables.
// - Slot 11 shared by line three and routed watchdog.
// - Low register bit map, bits 1:0 read zero.
// - High register bit map, bits 15:11 read zero.
// - Pins double-synchronised, request on 1-0-0-0 pattern.
// - Vector fetch pulses acknowledge low; a hardware fetch clears its flag.
package irq_vector_pkg;

	// Number of vector slots and external request lines.
	localparam int SLOTS = 32;
	localparam int EXT_LINES = 5;

	// Register indices on the local register port.
	localparam logic [2:0] ADDR_EN_LOW = 3'h0;
	localparam logic [2:0] ADDR_EN_HIGH = 3'h1;
	localparam logic [2:0] ADDR_FLAG_LOW = 3'h2;
	localparam logic [2:0] ADDR_FLAG_HIGH = 3'h3;
	localparam logic [2:0] ADDR_HALT_LOW = 3'h4;
	localparam logic [2:0] ADDR_HALT_HIGH = 3'h5;
	localparam logic [2:0] ADDR_STATUS = 3'h6;

	// Implemented bits of the low and high registers; others read zero.
	localparam logic [15:0] LOW_VALID = 16'hfffc;
	localparam logic [15:0] HIGH_VALID = 16'h07ff;
	localparam logic [15:0] REG_RESET = 16'h0000;

	// Slots with dedicated hardware handling.
	localparam logic [4:0] SLOT_RESET = 5'h00;
	localparam logic [4:0] SLOT_NMI = 5'h01;
	localparam logic [4:0] SLOT_LINE3 = 5'h0b;

	// Slot of each external line, index 0 to 4.
	localparam logic [4:0] LINE_SLOT [EXT_LINES] = '{5'h02, 5'h10, 5'h03, 5'h0b, 5'h13};

	// Pin history that marks a request: high, then two lows; the current sample must be low too.
	localparam logic [2:0] PIN_HIST_HIGH_LOW = 3'h4;

	// Shift that turns a slot number into a byte offset of eight per slot.
	localparam int VEC_SHIFT = 3;

	// Request from the core: a vector fetch of a slot, trap or hardware.
	typedef struct packed {
		logic fetch;
		logic is_trap;
		logic [4:0] slot;
	} core_fetch_t;

	// Local register port request.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [2:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	// Fixed priority of each slot; smaller is more urgent.
	function automatic logic [4:0] slot_priority(input logic [4:0] s);
		logic [4:0] p;
		p = s;
		unique case (s)
			5'h02: p = 5'h03;
			5'h03: p = 5'h05;
			5'h04: p = 5'h06;
			5'h05: p = 5'h07;
			5'h06: p = 5'h09;
			5'h07: p = 5'h0a;
			5'h08: p = 5'h0b;
			5'h09: p = 5'h0d;
			5'h0a: p = 5'h0e;
			5'h0b: p = 5'h0f;
			5'h0c: p = 5'h11;
			5'h0d: p = 5'h12;
			5'h0e: p = 5'h15;
			5'h0f: p = 5'h16;
			5'h10: p = 5'h04;
			5'h11: p = 5'h08;
			5'h12: p = 5'h0c;
			5'h13: p = 5'h10;
			5'h14: p = 5'h13;
			5'h15: p = 5'h14;
			5'h16: p = 5'h17;
			5'h17: p = 5'h18;
			5'h18: p = 5'h02;
			5'h19: p = 5'h19;
			5'h1a: p = 5'h1a;
			default: p = s;
		endcase
		return p;
	endfunction

	// Byte offset of a slot's vector from the vector base.
	function automatic logic [7:0] vector_offset(input logic [4:0] s);
		return 8'({s, 3'h0});
	endfunction

endpackage

// file: hw/dsp_interrupt_vector_mask_unit.sv
// Interrupt flag, enable and halted-enable logic with vector and priority selection.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ns
module dsp_interrupt_vector_mask_unit (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clk_en,
	// Local register port.
	input wire irq_vector_pkg::reg_req_t reg_req,
	output logic [15:0] reg_rdata,
	// External request pins, active low, and the nonmaskable pin.
	input wire logic [irq_vector_pkg::EXT_LINES-1:0] ext_line_b,
	input wire logic nmi_b,
	// Internal sources, one pulse bit per slot.
	input wire logic [irq_vector_pkg::SLOTS-1:0] src_req,
	input wire logic watchdog_request,
	input wire logic watchdog_routed,
	// Core status and requests.
	input wire logic core_halted_rt,
	input wire logic soft_reset,
	input wire irq_vector_pkg::core_fetch_t core_fetch,
	// Presented request towards the core.
	output logic irq_present,
	output logic [4:0] irq_slot,
	output logic [7:0] irq_vector,
	output logic vector_fetch_ack_b
);

	////////////////////////////////////////////////////////////////////////////////
	// State.

	// All state of the block in one record.
	typedef struct packed {
		logic [15:0] en_lo;
		logic [15:0] en_hi;
		logic [15:0] flag_lo;
		logic [15:0] flag_hi;
		logic [15:0] halt_lo;
		logic [15:0] halt_hi;
		logic reset_pend;
		logic nmi_pend;
		logic [irq_vector_pkg::EXT_LINES:0] sync1;
		logic [irq_vector_pkg::EXT_LINES:0] sync2;
		logic [irq_vector_pkg::EXT_LINES:0][2:0] hist;
		logic present;
		logic [4:0] slot;
		logic [7:0] vector;
		logic ack_b;
		logic [15:0] rdata;
	} state_t;

	// Reset value: every register zero, pins idle high, reset vector pending.
	localparam state_t STATE_RESET = '{
		en_lo: irq_vector_pkg::REG_RESET,
		en_hi: irq_vector_pkg::REG_RESET,
		flag_lo: irq_vector_pkg::REG_RESET,
		flag_hi: irq_vector_pkg::REG_RESET,
		halt_lo: irq_vector_pkg::REG_RESET,
		halt_hi: irq_vector_pkg::REG_RESET,
		reset_pend: 1'b1,
		nmi_pend: 1'b0,
		sync1: '1,
		sync2: '1,
		hist: '1,
		present: 1'b0,
		slot: irq_vector_pkg::SLOT_RESET,
		vector: 8'h00,
		ack_b: 1'b1,
		rdata: irq_vector_pkg::REG_RESET
	};

	state_t state_reg; // Registered state.
	state_t state_next; // Next state.

	logic [irq_vector_pkg::EXT_LINES:0] line_detect; // One-cycle pin request pulses.
	logic [31:0] flag_set; // Slots raised this cycle.
	logic [31:0] flag_clr; // Slots cleared this cycle.
	logic [31:0] flags_all; // Both flag registers side by side.
	logic [31:0] valid_all; // Implemented flag bits.
	logic [31:0] eligible; // Maskable slots allowed through to the core.
	logic [4:0] best_slot; // Winning slot.
	logic [4:0] best_prio; // Priority of the winning slot.
	logic best_any; // Some slot is eligible.

	assign flags_all = {state_reg.flag_hi, state_reg.flag_lo};
	assign valid_all = {irq_vector_pkg::HIGH_VALID, irq_vector_pkg::LOW_VALID};

	////////////////////////////////////////////////////////////////////////////////
	// Pin pattern detection.

	// A request needs a high sample and then three lows in a row, so a glitch of
	// one or two cycles never becomes an interrupt.
	always_comb begin
		for (int i = 0; i <= irq_vector_pkg::EXT_LINES; i++) begin
			line_detect[i] = (state_reg.hist[i] == irq_vector_pkg::PIN_HIST_HIGH_LOW)
				&& !state_reg.sync2[i];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Set and clear terms of the flags.

	// Sources that raise flags, and the bus and fetch terms that drop them.
	always_comb begin
		flag_set = src_req;
		for (int i = 0; i < irq_vector_pkg::EXT_LINES; i++) begin
			flag_set[irq_vector_pkg::LINE_SLOT[i]] = line_detect[i];
		end
		// Watchdog shares slot 11 only when it is routed there.
		flag_set[irq_vector_pkg::SLOT_LINE3] = line_detect[3]
			|| (watchdog_request && watchdog_routed);
		flag_set = flag_set & valid_all;
		flag_clr = '0;
		// Writing a one to a flag bit drops it.
		if (reg_req.wr && reg_req.addr == irq_vector_pkg::ADDR_FLAG_LOW) begin
			flag_clr[15:0] = reg_req.wdata;
		end
		if (reg_req.wr && reg_req.addr == irq_vector_pkg::ADDR_FLAG_HIGH) begin
			flag_clr[31:16] = reg_req.wdata;
		end
		// A hardware vector fetch drops that slot; a trap leaves flags alone.
		if (core_fetch.fetch && !core_fetch.is_trap) begin
			flag_clr[core_fetch.slot] = 1'b1;
		end
		// Software reset drops every flag at once.
		if (soft_reset) begin
			flag_clr = '1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Masking and priority selection.

	// Halted-enable bits only count while the core is halted in real-time mode.
	always_comb begin
		if (core_halted_rt) begin
			eligible = flags_all & {state_reg.en_hi, state_reg.en_lo}
				& {state_reg.halt_hi, state_reg.halt_lo};
		end else begin
			eligible = flags_all & {state_reg.en_hi, state_reg.en_lo};
		end
	end

	// Linear search for the smallest priority value; ties cannot occur.
	always_comb begin
		best_any = 1'b0;
		best_slot = irq_vector_pkg::SLOT_RESET;
		best_prio = '1;
		if (state_reg.reset_pend) begin
			best_any = 1'b1;
			best_slot = irq_vector_pkg::SLOT_RESET;
			best_prio = irq_vector_pkg::slot_priority(irq_vector_pkg::SLOT_RESET);
		end else if (state_reg.nmi_pend) begin
			best_any = 1'b1;
			best_slot = irq_vector_pkg::SLOT_NMI;
			best_prio = irq_vector_pkg::slot_priority(irq_vector_pkg::SLOT_NMI);
		end else begin
			for (int i = 0; i < irq_vector_pkg::SLOTS; i++) begin
				if (eligible[i] && (!best_any
					|| irq_vector_pkg::slot_priority(5'(i)) < best_prio)) begin
					best_any = 1'b1;
					best_slot = 5'(i);
					best_prio = irq_vector_pkg::slot_priority(5'(i));
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	// Builds the whole next state; writes and hardware events merge here.
	always_comb begin
		logic [31:0] flags_new;
		flags_new = '0;
		state_next = state_reg;
		// Two-stage synchroniser, then a three-deep history behind it.
		state_next.sync1 = {nmi_b, ext_line_b};
		state_next.sync2 = state_reg.sync1;
		for (int i = 0; i <= irq_vector_pkg::EXT_LINES; i++) begin
			state_next.hist[i] = {state_reg.hist[i][1:0], state_reg.sync2[i]};
		end
		// Set wins over clear, so an event in the clearing cycle survives.
		flags_new = ((flags_all & ~flag_clr) | flag_set) & valid_all;
		state_next.flag_lo = flags_new[15:0];
		state_next.flag_hi = flags_new[31:16];
		// Nonmaskable pin keeps its own pending bit outside the flag registers.
		if (line_detect[irq_vector_pkg::EXT_LINES]) begin
			state_next.nmi_pend = 1'b1;
		end else if (core_fetch.fetch && !core_fetch.is_trap
			&& core_fetch.slot == irq_vector_pkg::SLOT_NMI) begin
			state_next.nmi_pend = 1'b0;
		end
		// Software reset re-enters through the reset vector.
		if (soft_reset) begin
			state_next.reset_pend = 1'b1;
		end else if (core_fetch.fetch && core_fetch.slot == irq_vector_pkg::SLOT_RESET) begin
			state_next.reset_pend = 1'b0;
		end
		// Enable and halted-enable writes store what software gives, masked to the implemented bits.
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				irq_vector_pkg::ADDR_EN_LOW: begin
					state_next.en_lo = reg_req.wdata & irq_vector_pkg::LOW_VALID;
				end
				irq_vector_pkg::ADDR_EN_HIGH: begin
					state_next.en_hi = reg_req.wdata & irq_vector_pkg::HIGH_VALID;
				end
				irq_vector_pkg::ADDR_HALT_LOW: begin
					state_next.halt_lo = reg_req.wdata & irq_vector_pkg::LOW_VALID;
				end
				irq_vector_pkg::ADDR_HALT_HIGH: begin
					state_next.halt_hi = reg_req.wdata & irq_vector_pkg::HIGH_VALID;
				end
				default: begin
					// Flag writes are handled above; other indices are ignored.
				end
			endcase
		end
		// Read data stands only in the cycle after the read strobe.
		state_next.rdata = irq_vector_pkg::REG_RESET;
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				irq_vector_pkg::ADDR_EN_LOW: state_next.rdata = state_reg.en_lo;
				irq_vector_pkg::ADDR_EN_HIGH: state_next.rdata = state_reg.en_hi;
				irq_vector_pkg::ADDR_FLAG_LOW: state_next.rdata = state_reg.flag_lo;
				irq_vector_pkg::ADDR_FLAG_HIGH: state_next.rdata = state_reg.flag_hi;
				irq_vector_pkg::ADDR_HALT_LOW: state_next.rdata = state_reg.halt_lo;
				irq_vector_pkg::ADDR_HALT_HIGH: state_next.rdata = state_reg.halt_hi;
				irq_vector_pkg::ADDR_STATUS: begin
					state_next.rdata = 16'({core_halted_rt, state_reg.nmi_pend,
						state_reg.reset_pend, state_reg.present, state_reg.slot});
				end
				default: state_next.rdata = irq_vector_pkg::REG_RESET;
			endcase
		end
		// Presented vector follows the winner one cycle later.
		state_next.present = best_any;
		state_next.slot = best_slot;
		state_next.vector = irq_vector_pkg::vector_offset(best_slot);
		// Acknowledge is low for exactly the cycle after a fetch.
		state_next.ack_b = !core_fetch.fetch;
	end

	// State register; the clock enable freezes everything while low.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= STATE_RESET;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata = state_reg.rdata;
	assign irq_present = state_reg.present;
	assign irq_slot = state_reg.slot;
	assign irq_vector = state_reg.vector;
	assign vector_fetch_ack_b = state_reg.ack_b;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	chk_vector_slot_offset: assert property (
		@(posedge clock) disable iff (!rst_b)
		irq_vector == 8'({irq_slot, 3'h0}))
		else $error("Vector offset is not eight times the slot.");

	chk_ack_single_low: assert property (
		@(posedge clock) disable iff (!rst_b)
		clk_en && core_fetch.fetch ##1 clk_en && !core_fetch.fetch
		|-> !vector_fetch_ack_b ##1 vector_fetch_ack_b)
		else $error("Acknowledge did not pulse low for one cycle.");

	chk_fetch_clears_flag: assert property (
		@(posedge clock) disable iff (!rst_b)
		clk_en && core_fetch.fetch && !core_fetch.is_trap && !flag_set[core_fetch.slot]
		|=> !flags_all[$past(core_fetch.slot)])
		else $error("Fetched slot flag was not cleared.");

	chk_soft_reset_flags: assert property (
		@(posedge clock) disable iff (!rst_b)
		clk_en && soft_reset && flag_set == '0
		|=> flags_all == '0 && state_reg.en_lo == $past(state_reg.en_lo)
			&& state_reg.en_hi == $past(state_reg.en_hi)
			&& state_reg.halt_lo == $past(state_reg.halt_lo))
		else $error("Software reset did not clear flags only.");

	chk_halted_gating: assert property (
		@(posedge clock) disable iff (!rst_b)
		clk_en && core_halted_rt && !state_reg.reset_pend && !state_reg.nmi_pend && best_any
		|-> (best_slot[4] ? state_reg.halt_hi[best_slot[3:0]]
			: state_reg.halt_lo[best_slot[3:0]]))
		else $error("Halted core was offered a non time-critical slot.");

	chk_running_ignores_halt: assert property (
		@(posedge clock) disable iff (!rst_b)
		!core_halted_rt && (flags_all & {state_reg.en_hi, state_reg.en_lo}) != '0
		&& !state_reg.reset_pend && !state_reg.nmi_pend |-> best_any)
		else $error("Running core lost an enabled request.");

	chk_pin_pattern: assert property (
		@(posedge clock) disable iff (!rst_b)
		clk_en && line_detect[0] |=> flags_all[irq_vector_pkg::LINE_SLOT[0]])
		else $error("Line zero pattern did not raise its flag.");

	chk_reserved_zero: assert property (
		@(posedge clock) disable iff (!rst_b)
		(state_reg.flag_hi & ~irq_vector_pkg::HIGH_VALID) == '0
		&& (state_reg.flag_lo & ~irq_vector_pkg::LOW_VALID) == '0)
		else $error("Reserved flag bit is set.");

	chk_reset_first: assert property (
		@(posedge clock) disable iff (!rst_b)
		clk_en && state_reg.reset_pend |=> irq_present && irq_slot == irq_vector_pkg::SLOT_RESET)
		else $error("Reset vector was not presented first.");

	// The checks below guard the paths that ordinary traffic rarely exercises.
	chk_trap_keeps_flags: assert property (
		@(posedge clock) disable iff (!rst_b)
		clk_en && core_fetch.fetch && core_fetch.is_trap && !soft_reset && !reg_req.wr
		&& flag_set == '0 |=> flags_all == $past(flags_all))
		else $error("Trap fetch changed a pending flag.");

	chk_watchdog_route: assert property (
		@(posedge clock) disable iff (!rst_b)
		clk_en && watchdog_request && watchdog_routed
		|=> flags_all[irq_vector_pkg::SLOT_LINE3])
		else $error("Routed watchdog did not raise the shared slot.");

	chk_watchdog_unrouted: assert property (
		@(posedge clock) disable iff (!rst_b)
		!watchdog_routed && !line_detect[3]
		|-> !flag_set[irq_vector_pkg::SLOT_LINE3])
		else $error("Unrouted watchdog raised the shared slot.");

	chk_hw_reset_clear: assert property (
		@(posedge clock) disable iff (!rst_b)
		$rose(rst_b) |-> flags_all == '0 && {state_reg.en_hi, state_reg.en_lo} == '0
			&& {state_reg.halt_hi, state_reg.halt_lo} == '0)
		else $error("Hardware reset left a register set.");

	chk_ack_idle_high: assert property (
		@(posedge clock) disable iff (!rst_b)
		clk_en && !core_fetch.fetch
		|=> vector_fetch_ack_b)
		else $error("Acknowledge went low without a fetch.");

endmodule

// file: verif/core_model.sv
// Behavioural core that fetches the presented vector or a trap vector.
`timescale 1ns/1ns
module core_model (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic take,
	input wire logic trap,
	input wire logic [4:0] trap_slot,
	input wire logic irq_present,
	input wire logic [4:0] irq_slot,
	output irq_vector_pkg::core_fetch_t core_fetch
);
	////////////////////////////////////////////////////////////////
	// A hardware fetch names only the slot on offer, as a real core never
	// jumps to a request the unit did not present; a trap names any slot.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			core_fetch <= '0;
		end else if (take && (trap || irq_present)) begin
			core_fetch <= {1'b1, trap, trap ? trap_slot : irq_slot};
		end else begin
			core_fetch <= '0;
		end
	end
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the interrupt vector and mask unit.
`timescale 1ns/1ns
module tb_top;
	// Stimulus, all given a value at time zero; pins idle high.
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic clk_en = 1'b1;
	irq_vector_pkg::reg_req_t reg_req = '0;
	logic [4:0] ext_line_b = 5'h1f;
	logic nmi_b = 1'b1;
	logic [31:0] src_req = 32'h0;
	logic watchdog_request = 1'b0;
	logic watchdog_routed = 1'b0;
	logic core_halted_rt = 1'b0;
	logic soft_reset = 1'b0;
	logic take = 1'b0;
	logic trap = 1'b0;
	logic [4:0] trap_slot = 5'h00;
	// Observed outputs.
	irq_vector_pkg::core_fetch_t core_fetch;
	logic [15:0] reg_rdata;
	logic irq_present;
	logic [4:0] irq_slot;
	logic [7:0] irq_vector;
	logic vector_fetch_ack_b;
	int fails = 0;
	int comparisons = 0;
	// Slot of each external line, zero to four.
	logic [4:0] line_slot [5] = '{5'h02, 5'h10, 5'h03, 5'h0b, 5'h13};

	always #10 clock = ~clock;

	////////////////////////////////////////////////////////////////
	// The clock enable is driven so that the freeze scenario can drop it.
	dsp_interrupt_vector_mask_unit dsp_interrupt_vector_mask_unit_inst (.clock(clock),
		.rst_b(rst_b), .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.ext_line_b(ext_line_b), .nmi_b(nmi_b), .src_req(src_req),
		.watchdog_request(watchdog_request), .watchdog_routed(watchdog_routed),
		.core_halted_rt(core_halted_rt), .soft_reset(soft_reset), .core_fetch(core_fetch),
		.irq_present(irq_present), .irq_slot(irq_slot), .irq_vector(irq_vector),
		.vector_fetch_ack_b(vector_fetch_ack_b));
	core_model core_model_inst (.clock(clock), .rst_b(rst_b), .take(take), .trap(trap),
		.trap_slot(trap_slot), .irq_present(irq_present), .irq_slot(irq_slot),
		.core_fetch(core_fetch));

	////////////////////////////////////////////////////////////////
	// Wait edges, then 1 ns so that the edge's updates have landed.
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Compare a data word.
	task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Compare the presented request; the vector must be eight bytes a slot.
	task automatic check_irq(input logic present, input logic [4:0] slot);
		comparisons++;
		if (irq_present !== present
			|| (present && (irq_slot !== slot || irq_vector !== {slot, 3'h0}))) begin
			fails++;
			$display("unexpected at %0t: present %b slot %h", $time, irq_present, irq_slot);
		end
	endtask
	// One-cycle register write and read; read data stand the next cycle only.
	task automatic reg_wr(input logic [2:0] addr, input logic [15:0] data);
		@(posedge clock);
		reg_req <= {1'b1, 1'b0, addr, data};
		@(posedge clock);
		reg_req <= '0;
	endtask
	task automatic reg_rd(input logic [2:0] addr, input logic [15:0] exp);
		@(posedge clock);
		reg_req <= {1'b0, 1'b1, addr, 16'h0000};
		@(posedge clock);
		reg_req <= '0;
		#1 check_word(reg_rdata, exp);
	endtask
	// One-cycle source pulse, then room for flag and selection.
	task automatic pulse_src(input logic [31:0] v);
		@(posedge clock);
		src_req <= v;
		@(posedge clock);
		src_req <= '0;
		tick(2);
	endtask
	// Pull the chosen pins, nonmaskable on top, low for a number of samples.
	task automatic pins(input logic [5:0] mask, input int lows);
		@(posedge clock);
		{nmi_b, ext_line_b} <= ~mask;
		repeat (lows) @(posedge clock);
		{nmi_b, ext_line_b} <= 6'h3f;
		tick(8);
	endtask
	// Core fetch through the model; acknowledge is low for exactly one cycle.
	task automatic fetch(input logic tr, input logic [4:0] ts);
		@(posedge clock);
		take <= 1'b1;
		trap <= tr;
		trap_slot <= ts;
		@(posedge clock);
		take <= 1'b0;
		@(posedge clock);
		#1 check_word({15'h0, vector_fetch_ack_b}, 16'h0000);
		tick(1);
		check_word({15'h0, vector_fetch_ack_b}, 16'h0001);
		tick(1);
	endtask
	task automatic watchdog_pulse();
		@(posedge clock);
		watchdog_request <= 1'b1;
		@(posedge clock);
		watchdog_request <= 1'b0;
		tick(2);
	endtask

	////////////////////////////////////////////////////////////////
	// Reset values, unmapped index, the reset slot, then reserved bits.
	task automatic test_reset_layout();
		for (int a = 0; a < 6; a++) reg_rd(3'(a), 16'h0000);
		reg_rd(3'h7, 16'h0000);
		reg_rd(3'h6, 16'h0060);
		check_irq(1'b1, 5'h00);
		fetch(1'b0, 5'h00);
		reg_wr(3'h0, 16'hffff);
		reg_wr(3'h1, 16'hffff);
		reg_rd(3'h0, 16'hfffc);
		reg_rd(3'h1, 16'h07ff);
		$display("test reset_layout done");
	endtask
	// Three sources at once leave in order of priority value.
	task automatic test_priority();
		pulse_src(32'h0102_0010);
		check_irq(1'b1, 5'h18);
		fetch(1'b0, 5'h00);
		reg_rd(3'h3, 16'h0002);
		check_irq(1'b1, 5'h04);
		fetch(1'b0, 5'h00);
		check_irq(1'b1, 5'h11);
		fetch(1'b0, 5'h00);
		check_irq(1'b0, 5'h00);
		$display("test priority done");
	endtask
	// Normal masking, then halted masking through both enable sets.
	task automatic test_mask();
		reg_wr(3'h0, 16'h0000);
		reg_wr(3'h1, 16'h0000);
		pulse_src(32'h0000_0020);
		reg_rd(3'h2, 16'h0020);
		check_irq(1'b0, 5'h00);
		@(posedge clock);
		core_halted_rt <= 1'b1;
		reg_wr(3'h0, 16'h0020);
		tick(2);
		check_irq(1'b0, 5'h00);
		reg_wr(3'h4, 16'h0020);
		tick(2);
		check_irq(1'b1, 5'h05);
		reg_wr(3'h0, 16'h0000);
		tick(2);
		check_irq(1'b0, 5'h00);
		@(posedge clock);
		core_halted_rt <= 1'b0;
		reg_wr(3'h0, 16'h0020);
		reg_wr(3'h4, 16'h0000);
		tick(2);
		check_irq(1'b1, 5'h05);
		fetch(1'b0, 5'h00);
		$display("test mask done");
	endtask
	// Software reset clears flags only; traps need no enable and clear nothing.
	task automatic test_soft_trap();
		reg_wr(3'h5, 16'h0400);
		reg_wr(3'h1, 16'h0400);
		pulse_src(32'h0400_0000);
		check_irq(1'b1, 5'h1a);
		@(posedge clock);
		soft_reset <= 1'b1;
		@(posedge clock);
		soft_reset <= 1'b0;
		tick(2);
		reg_rd(3'h3, 16'h0000);
		reg_rd(3'h1, 16'h0400);
		reg_rd(3'h5, 16'h0400);
		fetch(1'b0, 5'h00);
		reg_wr(3'h1, 16'h0000);
		pulse_src(32'h0400_0000);
		fetch(1'b1, 5'h1f);
		fetch(1'b1, 5'h1a);
		reg_rd(3'h3, 16'h0400);
		reg_wr(3'h3, 16'h0400);
		reg_rd(3'h3, 16'h0000);
		$display("test soft_trap done");
	endtask
	// Every pin at the shortest low, a too-short low, the watchdog and the nonmaskable.
	task automatic test_pins();
		logic [31:0] exp;
		reg_wr(3'h0, 16'hffff);
		reg_wr(3'h1, 16'hffff);
		for (int i = 0; i < 5; i++) begin
			exp = 32'h1 << line_slot[i];
			pins(6'(1 << i), 3);
			reg_rd(3'h2, exp[15:0]);
			reg_rd(3'h3, exp[31:16]);
			check_irq(1'b1, line_slot[i]);
			fetch(1'b0, 5'h00);
		end
		pins(6'h08, 2);
		reg_rd(3'h2, 16'h0000);
		pins(6'h06, 3);
		check_irq(1'b1, 5'h10);
		fetch(1'b0, 5'h00);
		check_irq(1'b1, 5'h03);
		fetch(1'b0, 5'h00);
		watchdog_pulse();
		reg_rd(3'h2, 16'h0000);
		@(posedge clock);
		watchdog_routed <= 1'b1;
		watchdog_pulse();
		reg_rd(3'h2, 16'h0800);
		reg_wr(3'h0, 16'h0000);
		reg_wr(3'h2, 16'h0800);
		pins(6'h20, 3);
		check_irq(1'b1, 5'h01);
		fetch(1'b0, 5'h00);
		check_irq(1'b0, 5'h00);
		$display("test pins done");
	endtask
	// A second hardware reset in mid-run clears enables, halted enables and flags.
	task automatic test_hw_reset();
		reg_wr(3'h0, 16'h0010);
		reg_wr(3'h4, 16'h0010);
		pulse_src(32'h0000_0010);
		check_irq(1'b1, 5'h04);
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		tick(1);
		check_irq(1'b1, 5'h00);
		reg_rd(3'h0, 16'h0000);
		reg_rd(3'h2, 16'h0000);
		reg_rd(3'h4, 16'h0000);
		fetch(1'b0, 5'h00);
		$display("test hw_reset done");
	endtask
	// With the clock enable low a write and a source pulse are both lost.
	task automatic test_freeze();
		@(posedge clock);
		clk_en <= 1'b0;
		reg_wr(3'h0, 16'h0020);
		pulse_src(32'h0000_0020);
		@(posedge clock);
		clk_en <= 1'b1;
		reg_rd(3'h0, 16'h0000);
		reg_rd(3'h2, 16'h0000);
		$display("test freeze done");
	endtask

	////////////////////////////////////////////////////////////////
	// Verdict; reached from the main sequence or the watchdog.
	task automatic tally_and_finish();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Main sequence after twelve cycles of reset.
	initial begin
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		tick(1);
		test_reset_layout();
		test_priority();
		test_mask();
		test_soft_trap();
		test_pins();
		test_hw_reset();
		test_freeze();
		tally_and_finish();
	end
	// The tests need some 360 cycles; nearly thirty times that means a hang.
	initial begin
		#200000;
		fails++;
		$display("unexpected at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule
